// >>> include/rtc_pwc_defs.vh
// Register map, field positions, reset values and timing counts of the
// always-on domain power control block.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef RTC_PWC_DEFS_VH
`define RTC_PWC_DEFS_VH

// Register indices; byte address is four times the index
`define PWC_IDX_LP_CTRL 8'h20
`define PWC_IDX_DIG_CTRL 8'h21
`define PWC_IDX_STATUS 8'h3F
`define PWC_ADDR_LSB 2

// Low-power domain power control fields
`define PWC_PERIPH_SLEEP_OFF_EN 21
`define PWC_PERIPH_FORCE_ON 20
`define PWC_PERIPH_FORCE_OFF 19
`define PWC_SLOW_SLEEP_OFF_EN 18
`define PWC_SLOW_FORCE_ON 17
`define PWC_SLOW_FORCE_OFF 16
`define PWC_FAST_SLEEP_OFF_EN 15
`define PWC_FAST_FORCE_ON 14
`define PWC_FAST_FORCE_OFF 13
`define PWC_SLOW_LP_FORCE_ON 12
`define PWC_SLOW_LP_FORCE_OFF 11
`define PWC_SLOW_TRACK_CPU 10
`define PWC_FAST_LP_FORCE_ON 9
`define PWC_FAST_LP_FORCE_OFF 8
`define PWC_FAST_TRACK_CPU 7
`define PWC_PERIPH_FORCE_CONNECT 6
`define PWC_PERIPH_FORCE_ISOLATE 5
`define PWC_SLOW_FORCE_ISOLATE 4
`define PWC_SLOW_FORCE_CONNECT 3
`define PWC_FAST_FORCE_ISOLATE 2
`define PWC_FAST_FORCE_CONNECT 1

`define PWC_LP_CTRL_MASK 32'h003FFFFE
`define PWC_LP_CTRL_RESET 32'h00012924
`define PWC_DIG_CTRL_MASK 32'h00FFFFFF
`define PWC_DIG_CTRL_RESET 32'h00155550

// Cycles between isolation and power edges
`define PWC_SETTLE_CYCLES 4'h2

`endif

// >>> rtl/rtc_domain_power_control.v
// Power and isolation control for the three always-on domains:
// low-power peripherals (0), slow retention memory (1), fast retention memory (2).
// Assumes an APB master on i_ref_clk and sleep/low-power requests from
// logic on the same clock.
`timescale 1ns/10ps
`include "rtc_pwc_defs.vh"

module rtc_domain_power_control #(
    parameter NUM_DOMAINS = 3,
    parameter [3:0] SETTLE_CYCLES = `PWC_SETTLE_CYCLES
) (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_sleep,
    input wire i_lowpower_mode,
    input wire i_cpu_off_req,
    input wire i_fsm_mem_off_req,
    output wire [NUM_DOMAINS-1:0] o_domain_power_on,
    output wire [NUM_DOMAINS-1:0] o_domain_isolate
);

    // ************************************************************
    // APB slave
    // ************************************************************
    reg [31:0] lp_ctrl_ff;
    reg [31:0] dig_ctrl_ff;
    reg [31:0] prdata_ff;
    reg pready_ff;
    reg pslverr_ff;
    reg [31:0] nxt_prdata;
    reg nxt_pslverr;
    wire [NUM_DOMAINS-1:0] power_state;
    wire [NUM_DOMAINS-1:0] iso_state;
    wire [7:0] reg_index;
    wire addr_aligned;
    wire setup_phase;
    wire write_commit;

    assign reg_index = i_paddr[`PWC_ADDR_LSB+7:`PWC_ADDR_LSB];
    assign addr_aligned = (i_paddr[`PWC_ADDR_LSB-1:0] == 2'h0) &&
        (i_paddr[31:`PWC_ADDR_LSB+8] == 22'h000000);
    assign setup_phase = i_psel & ~i_penable;
    // Writes land only at the edge where the master sees pready high
    assign write_commit = i_psel & i_penable & pready_ff & i_pwrite & ~pslverr_ff;

    always @* begin
        nxt_prdata = 32'h00000000;
        nxt_pslverr = 1'b0;
        if (!addr_aligned) begin
            nxt_pslverr = 1'b1;
        end else begin
            case (reg_index)
                `PWC_IDX_LP_CTRL: begin
                    nxt_prdata = lp_ctrl_ff;
                end
                `PWC_IDX_DIG_CTRL: begin
                    nxt_prdata = dig_ctrl_ff;
                end
                `PWC_IDX_STATUS: begin
                    nxt_prdata = {26'h0000000, iso_state, power_state};
                    nxt_pslverr = i_pwrite;
                end
                default: begin
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
    end

    // Decode in the setup cycle so the access phase completes at once
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup_phase;
            pslverr_ff <= setup_phase & nxt_pslverr;
            if (setup_phase && !i_pwrite) begin
                prdata_ff <= nxt_prdata;
            end else if (!i_psel) begin
                prdata_ff <= 32'h00000000;
            end
        end
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lp_ctrl_ff <= `PWC_LP_CTRL_RESET;
            dig_ctrl_ff <= `PWC_DIG_CTRL_RESET;
        end else if (write_commit) begin
            if (reg_index == `PWC_IDX_LP_CTRL) begin
                lp_ctrl_ff <= i_pwdata & `PWC_LP_CTRL_MASK;
            end
            if (reg_index == `PWC_IDX_DIG_CTRL) begin
                dig_ctrl_ff <= i_pwdata & `PWC_DIG_CTRL_MASK;
            end
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;

    // ************************************************************
    // Per-domain control fields
    // ************************************************************
    wire [2:0] sleep_off_en;
    wire [2:0] force_on;
    wire [2:0] force_off;
    wire [2:0] lp_force_on;
    wire [2:0] lp_force_off;
    wire [2:0] track_cpu;
    wire [2:0] lp_tracked;
    wire [2:0] force_isolate;
    wire [2:0] force_connect;

    assign sleep_off_en = {lp_ctrl_ff[`PWC_FAST_SLEEP_OFF_EN],
        lp_ctrl_ff[`PWC_SLOW_SLEEP_OFF_EN], lp_ctrl_ff[`PWC_PERIPH_SLEEP_OFF_EN]};
    assign force_on = {lp_ctrl_ff[`PWC_FAST_FORCE_ON],
        lp_ctrl_ff[`PWC_SLOW_FORCE_ON], lp_ctrl_ff[`PWC_PERIPH_FORCE_ON]};
    assign force_off = {lp_ctrl_ff[`PWC_FAST_FORCE_OFF],
        lp_ctrl_ff[`PWC_SLOW_FORCE_OFF], lp_ctrl_ff[`PWC_PERIPH_FORCE_OFF]};
    assign lp_force_on = {lp_ctrl_ff[`PWC_FAST_LP_FORCE_ON],
        lp_ctrl_ff[`PWC_SLOW_LP_FORCE_ON], 1'b0};
    assign lp_force_off = {lp_ctrl_ff[`PWC_FAST_LP_FORCE_OFF],
        lp_ctrl_ff[`PWC_SLOW_LP_FORCE_OFF], 1'b0};
    assign track_cpu = {lp_ctrl_ff[`PWC_FAST_TRACK_CPU],
        lp_ctrl_ff[`PWC_SLOW_TRACK_CPU], 1'b0};
    // Only the memories follow low-power mode; peripherals follow sleep only
    assign lp_tracked = 3'h6;
    assign force_isolate = {lp_ctrl_ff[`PWC_FAST_FORCE_ISOLATE],
        lp_ctrl_ff[`PWC_SLOW_FORCE_ISOLATE], lp_ctrl_ff[`PWC_PERIPH_FORCE_ISOLATE]};
    assign force_connect = {lp_ctrl_ff[`PWC_FAST_FORCE_CONNECT],
        lp_ctrl_ff[`PWC_SLOW_FORCE_CONNECT], lp_ctrl_ff[`PWC_PERIPH_FORCE_CONNECT]};

    // ************************************************************
    // Power and isolation sequencers
    // ************************************************************
    localparam [3:0] ST_ON = 4'h1;
    localparam [3:0] ST_ISO_DOWN = 4'h2;
    localparam [3:0] ST_OFF = 4'h4;
    localparam [3:0] ST_PWR_UP = 4'h8;

    genvar d;
    generate
        for (d = 0; d < NUM_DOMAINS; d = d + 1) begin : g_domain
            reg [3:0] state_ff;
            reg [3:0] nxt_state;
            reg [3:0] cnt_ff;
            reg [3:0] nxt_cnt;
            reg power_ff;
            reg iso_seq_ff;
            reg iso_out_ff;
            reg nxt_power;
            reg nxt_iso_seq;
            reg auto_off;
            reg want_on;

            always @* begin
                auto_off = (i_sleep & sleep_off_en[d]);
                if (i_lowpower_mode && lp_tracked[d]) begin
                    if (track_cpu[d]) begin
                        auto_off = auto_off | i_cpu_off_req;
                    end else begin
                        auto_off = auto_off | i_fsm_mem_off_req;
                    end
                    if (lp_force_off[d]) begin
                        auto_off = 1'b1;
                    end
                    if (lp_force_on[d]) begin
                        auto_off = 1'b0;
                    end
                end
                // Force-on beats force-off: a stuck supply is safer than lost state
                if (force_on[d]) begin
                    want_on = 1'b1;
                end else if (force_off[d]) begin
                    want_on = 1'b0;
                end else begin
                    want_on = ~auto_off;
                end
            end

            always @* begin
                nxt_state = state_ff;
                nxt_cnt = 4'h0;
                nxt_power = power_ff;
                nxt_iso_seq = iso_seq_ff;
                case (state_ff)
                    ST_ON: begin
                        if (!want_on) begin
                            nxt_state = ST_ISO_DOWN;
                            nxt_iso_seq = 1'b1;
                        end
                    end
                    ST_ISO_DOWN: begin
                        if (want_on) begin
                            nxt_state = ST_ON;
                            nxt_iso_seq = 1'b0;
                        end else if (cnt_ff == SETTLE_CYCLES - 4'h1) begin
                            nxt_state = ST_OFF;
                            nxt_power = 1'b0;
                        end else begin
                            nxt_cnt = cnt_ff + 4'h1;
                        end
                    end
                    ST_OFF: begin
                        if (want_on) begin
                            nxt_state = ST_PWR_UP;
                            nxt_power = 1'b1;
                        end
                    end
                    ST_PWR_UP: begin
                        if (!want_on) begin
                            nxt_state = ST_ISO_DOWN;
                        end else if (cnt_ff == SETTLE_CYCLES - 4'h1) begin
                            nxt_state = ST_ON;
                            nxt_iso_seq = 1'b0;
                        end else begin
                            nxt_cnt = cnt_ff + 4'h1;
                        end
                    end
                    default: begin
                        nxt_state = ST_ON;
                        nxt_power = 1'b1;
                        nxt_iso_seq = 1'b0;
                    end
                endcase
            end

            always @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    state_ff <= ST_ON;
                    cnt_ff <= 4'h0;
                    power_ff <= 1'b1;
                    iso_seq_ff <= 1'b0;
                    iso_out_ff <= 1'b0;
                end else begin
                    state_ff <= nxt_state;
                    cnt_ff <= nxt_cnt;
                    power_ff <= nxt_power;
                    iso_seq_ff <= nxt_iso_seq;
                    // Force-isolate beats force-connect so a conflict never
                    // exposes an unpowered domain
                    iso_out_ff <= force_isolate[d] |
                        (~force_connect[d] & nxt_iso_seq);
                end
            end

            assign o_domain_power_on[d] = power_ff;
            assign o_domain_isolate[d] = iso_out_ff;
            assign power_state[d] = power_ff;
            assign iso_state[d] = iso_out_ff;
        end
    endgenerate

endmodule

// >>> verif/rtc_pwc_chk.sv
// Concurrent checks for the domain power control block.
// Assumes only the top-level ports; attached by bind below.
`timescale 1ns/10ps
module rtc_pwc_chk #(parameter NUM_DOMAINS = 3) (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    input wire i_sleep,
    input wire i_lowpower_mode,
    input wire i_cpu_off_req,
    input wire i_fsm_mem_off_req,
    input wire [NUM_DOMAINS-1:0] o_domain_power_on,
    input wire [NUM_DOMAINS-1:0] o_domain_isolate
);
    // ********
    // Checks
    // ********
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_refused;
        s_setup ##0 (i_paddr[1:0] != 2'h0 || (i_pwrite && i_paddr == 32'h000000FC));
    endsequence
    AST_READY_AFTER_SETUP: assert property (s_setup |=> o_pready)
        else $error("ready missing after setup");
    AST_READY_ONE_CYCLE: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    AST_REFUSED: assert property (s_refused |=> o_pslverr)
        else $error("bad access not refused");
    AST_ERR_ZERO_DATA: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error without ready or with data");
    AST_IDLE_RDATA: assert property (!i_psel && !$past(i_psel) |-> o_prdata == 32'h0)
        else $error("read data not zero when idle");
    genvar k;
    generate
        for (k = 0; k < NUM_DOMAINS; k = k + 1) begin : g_dom
            AST_ISO_BEFORE_OFF: assert property (
                $fell(o_domain_power_on[k]) |-> $past(o_domain_isolate[k], 2))
                else $error("power removed before isolation");
            AST_ON_BEFORE_RELEASE: assert property (
                $fell(o_domain_isolate[k]) |-> $past(o_domain_power_on[k], 2))
                else $error("isolation released before power");
            AST_ISO_TRAILS_ON: assert property (
                $rose(o_domain_power_on[k]) |-> o_domain_isolate[k] [*2])
                else $error("isolation dropped with power");
        end
    endgenerate
endmodule
bind rtc_domain_power_control rtc_pwc_chk #(.NUM_DOMAINS(NUM_DOMAINS)) u_rtc_pwc_chk (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sleep(i_sleep),
    .i_lowpower_mode(i_lowpower_mode), .i_cpu_off_req(i_cpu_off_req),
    .i_fsm_mem_off_req(i_fsm_mem_off_req), .o_domain_power_on(o_domain_power_on),
    .o_domain_isolate(o_domain_isolate));

// >>> verif/tb_top.sv
// Self-checking bench for the domain power control block.
// Assumes byte addresses 0x80, 0x84, 0xFC and a 25 MHz clock.
`timescale 1ns/10ps
module tb_top;
    reg i_ref_clk = 1'b0;
    reg i_rst_n = 1'b0;
    reg i_psel = 1'b0;
    reg i_penable = 1'b0;
    reg i_pwrite = 1'b0;
    reg [31:0] i_paddr = 32'h0;
    reg [31:0] i_pwdata = 32'h0;
    reg i_sleep = 1'b0;
    reg i_lowpower_mode = 1'b0;
    reg i_cpu_off_req = 1'b0;
    reg i_fsm_mem_off_req = 1'b0;
    wire [31:0] o_prdata;
    wire o_pready;
    wire o_pslverr;
    wire [2:0] o_domain_power_on;
    wire [2:0] o_domain_isolate;
    integer failures = 0;
    integer samples_checked = 0;
    integer cycles = 0;
    integer i;
    integer j;
    reg [15:0] seed = 16'h8152;
    reg [31:0] rd;
    reg err;
    reg [31:0] ctrl;
    // Low-power force entries also carry sleep enables so a low-power force-on meets sleep
    localparam [287:0] CTRLS = {32'h00008A00, 32'h0012402C, 32'h00124052, 32'h00124000,
        32'h00000480, 32'h00049100, 32'h000A2000, 32'h00114000, 32'h00248000};
    rtc_domain_power_control u_rtc_domain_power_control (.i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_sleep(i_sleep), .i_lowpower_mode(i_lowpower_mode),
        .i_cpu_off_req(i_cpu_off_req), .i_fsm_mem_off_req(i_fsm_mem_off_req),
        .o_domain_power_on(o_domain_power_on), .o_domain_isolate(o_domain_isolate));
    // ********
    // Helpers
    // ********
    always #20 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            wrap_up;
        end
    end
    function [15:0] lfsr(input [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Input order is {fsm, cpu, lowpower, sleep}
    function [2:0] want(input [31:0] c, input [3:0] n);
        begin
            want[0] = c[20] | !(c[19] | n[0] & c[21]);
            // A low-power force-on fixes the memory on in low-power mode, sleep included
            want[1] = c[17] | !c[16] & (n[1] & c[12] |
                !(n[0] & c[18] | n[1] & (c[11] | (c[10] ? n[2] : n[3]))));
            want[2] = c[14] | !c[13] & (n[1] & c[9] |
                !(n[0] & c[15] | n[1] & (c[8] | (c[7] ? n[2] : n[3]))));
        end
    endfunction
    function [2:0] iso_of(input [31:0] c, input [2:0] w);
        iso_of = {c[2] | !c[1] & !w[2], c[4] | !c[3] & !w[1], c[5] | !c[6] & !w[0]};
    endfunction
    task wrap_up;
        begin
            $display("compared %0d mismatched %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input wr, input [31:0] addr, input [31:0] data);
        begin
            @(posedge i_ref_clk);
            i_psel <= 1'b1;
            i_penable <= 1'b0;
            i_pwrite <= wr;
            i_paddr <= addr;
            i_pwdata <= data;
            @(posedge i_ref_clk);
            i_penable <= 1'b1;
            // Without pready, only the bench timeout ends this wait
            @(posedge i_ref_clk);
            while (o_pready !== 1'b1) begin
                @(posedge i_ref_clk);
            end
            rd = o_prdata;
            err = o_pslverr;
            i_psel <= 1'b0;
            i_penable <= 1'b0;
        end
    endtask
    task step(input integer n, input [2:0] ep, input [2:0] ei);
        begin
            repeat (n) @(posedge i_ref_clk);
            chk({29'h0, o_domain_power_on}, {29'h0, ep});
            chk({29'h0, o_domain_isolate}, {29'h0, ei});
        end
    endtask
    // ********
    // Sequence
    // ********
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        apb(1'b0, 32'h80, 32'h0);
        chk(rd, 32'h00012924);
        apb(1'b0, 32'h84, 32'h0);
        chk(rd, 32'h00155550);
        apb(1'b0, 32'hFC, 32'h0);
        chk(rd, 32'h00000039);
        apb(1'b1, 32'h82, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 32'hFC, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 32'h90, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b0, 32'h80, 32'h0);
        chk(rd, 32'h00012924);
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            apb(1'b1, 32'h84, {seed, ~seed});
            apb(1'b0, 32'h84, 32'h0);
            chk(rd, {seed, ~seed} & 32'h00FFFFFF);
        end
        apb(1'b1, 32'h80, 32'h00248000);
        step(6, 3'h7, 3'h0);
        i_sleep <= 1'b1;
        step(2, 3'h7, 3'h7);
        step(1, 3'h7, 3'h7);
        step(1, 3'h0, 3'h7);
        i_sleep <= 1'b0;
        step(2, 3'h7, 3'h7);
        step(1, 3'h7, 3'h7);
        step(1, 3'h7, 3'h0);
        for (i = 0; i < 9; i = i + 1) begin
            ctrl = CTRLS[i*32 +: 32];
            apb(1'b1, 32'h80, ctrl);
            for (j = 0; j < 4; j = j + 1) begin
                seed = lfsr(seed);
                {i_fsm_mem_off_req, i_cpu_off_req, i_lowpower_mode, i_sleep} <= seed[3:0];
                step(7, want(ctrl, seed[3:0]), iso_of(ctrl, want(ctrl, seed[3:0])));
            end
        end
        wrap_up;
    end
endmodule
